/* pkg/atrc_pkg.sv */
// Package with register map, field layout and timing constants of the converter timing control.
package atrc_pkg;

  // Register map.
  localparam logic [2:0] ATRC_ADDR_CONTROL3 = 3'h3;
  localparam logic [2:0] ATRC_ADDR_TIMING   = 3'h4;
  localparam logic [2:0] ATRC_ADDR_START    = 3'h5;
  localparam logic [2:0] ATRC_ADDR_STATUS   = 3'h6;

  // Field positions of the timing control register.
  localparam int ATRC_RES_BIT    = 7;
  localparam int ATRC_SMP_HI     = 6;
  localparam int ATRC_SMP_LO     = 5;
  localparam int ATRC_PRS_HI     = 4;
  localparam int ATRC_PRS_LO     = 0;

  // Reset values.
  localparam logic [7:0] ATRC_TIMING_RESET = 8'h05;
  localparam logic [7:0] ATRC_CTL3_RESET   = 8'h20;

  // Timing counts in conversion clock cycles, then the width and last value of the position counter.
  localparam logic [4:0] ATRC_PHASE1_CYC  = 5'h02;
  localparam logic [4:0] ATRC_BITS_HI_CYC = 5'h0A;
  localparam logic [4:0] ATRC_BITS_LO_CYC = 5'h08;
  localparam int         ATRC_POS_W       = 3;
  localparam logic [2:0] ATRC_POS_LAST    = 3'h7;

  typedef enum logic [1:0] {
    ATRC_IDLE,
    ATRC_SAMPLE1,
    ATRC_SAMPLE2,
    ATRC_CONVERT
  } atrc_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } atrc_bus_req_t;

  typedef struct packed {
    logic       running;
    logic [1:0] phase;
    logic [2:0] position;
    logic       done;
  } atrc_status_t;

endpackage : atrc_pkg

/* logic/atrc_prescaler.sv */
// Conversion clock prescaler: one enable pulse every 2*(P+1) bus cycles.
`timescale 1ns/1ps
module atrc_prescaler
  import atrc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Control
  input  wire logic [4:0] divider_i,
  input  wire logic       restart_i,
  // Conversion clock
  output logic            conv_tick_o,
  output logic            conv_clk_o
);

  typedef struct packed {
    logic [4:0] cnt;
    logic       clk;
    logic       tick;
  } atrc_pre_state_t;

  atrc_pre_state_t st_ff;
  atrc_pre_state_t nxt_st;

  // The tick marks the rising edge of the divided clock, so one tick is one full conversion period.
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (restart_i) begin
      nxt_st.cnt = 5'h00;
      nxt_st.clk = 1'b0;
    end else if (st_ff.cnt == divider_i) begin
      nxt_st.cnt  = 5'h00;
      nxt_st.clk  = ~st_ff.clk;
      nxt_st.tick = ~st_ff.clk;
    end else begin
      nxt_st.cnt = st_ff.cnt + 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign conv_tick_o = st_ff.tick;
  assign conv_clk_o  = st_ff.clk;

endmodule // atrc_prescaler

/* logic/atrc_timing_control.sv */
// Timing and resolution control of the converter sequencer with its register port.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module atrc_timing_control
  import atrc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Register port
  input  wire logic [2:0]   addr_i,
  input  wire logic [7:0]   wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic [7:0]        rdata_o,
  // Converter control
  output logic              conv_clk_o,
  output logic              low_resolution_select_o,
  output logic              sample_o,
  output logic              convert_o,
  output logic [2:0]        position_o,
  output logic              seq_done_o
);

  typedef struct packed {
    logic [7:0]  timing;
    logic [7:0]  ctl3;
    atrc_state_t state;
    logic [4:0]  cnt;
    logic [2:0]  position;
    logic [2:0]  convs;
    logic        done;
    logic [7:0]  rdata;
  } atrc_top_state_t;

  atrc_top_state_t st_ff;
  atrc_top_state_t nxt_st;
  atrc_bus_req_t   req;
  atrc_status_t    status;
  logic            conv_tick;
  logic            timing_wr;
  logic            abort;
  logic [4:0]      phase2_cyc;
  logic [4:0]      bits_cyc;
  logic [2:0]      seq_last;
  logic            fifo_mode;

  assign req       = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign timing_wr = req.wr && (req.addr == ATRC_ADDR_TIMING);
  // Writes to the third, fourth or fifth control register all abort the sequence in progress.
  assign abort     = req.wr && (req.addr == ATRC_ADDR_CONTROL3 || req.addr == ATRC_ADDR_TIMING
                                || req.addr == ATRC_ADDR_START);
  assign fifo_mode = st_ff.ctl3[2];
  assign seq_last  = (st_ff.ctl3[6:3] == 4'h0 || st_ff.ctl3[6]) ? 3'h7 : (st_ff.ctl3[5:3] - 3'h1);

  // Second phase lengths are 2 shifted by the field value.
  always_comb begin
    unique case (st_ff.timing[ATRC_SMP_HI:ATRC_SMP_LO])
      2'b00: phase2_cyc = 5'h02;
      2'b01: phase2_cyc = 5'h04;
      2'b10: phase2_cyc = 5'h08;
      2'b11: phase2_cyc = 5'h10;
    endcase
  end

  assign bits_cyc = st_ff.timing[ATRC_RES_BIT] ? ATRC_BITS_LO_CYC : ATRC_BITS_HI_CYC;

  atrc_prescaler u_prescaler (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .divider_i   (st_ff.timing[ATRC_PRS_HI:ATRC_PRS_LO]),
    .restart_i   (timing_wr),
    .conv_tick_o (conv_tick),
    .conv_clk_o  (conv_clk_o)
  );

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = 8'h00;
    // Reads see the value from before a write in the same cycle; nothing stops both strobes from being set at once.
    if (req.rd) begin
      unique case (req.addr)
        ATRC_ADDR_CONTROL3: nxt_st.rdata = st_ff.ctl3;
        ATRC_ADDR_TIMING:   nxt_st.rdata = st_ff.timing;
        ATRC_ADDR_STATUS:   nxt_st.rdata = {status.done, status.running, status.phase, 1'b0, status.position};
        default:            nxt_st.rdata = 8'h00;
      endcase
    end
    if (st_ff.state != ATRC_IDLE && conv_tick) begin
      nxt_st.cnt = st_ff.cnt + 5'h01;
      unique case (st_ff.state)
        ATRC_SAMPLE1: begin
          if (st_ff.cnt == ATRC_PHASE1_CYC - 5'h01) begin
            nxt_st.state = ATRC_SAMPLE2;
            nxt_st.cnt   = 5'h00;
          end
        end
        ATRC_SAMPLE2: begin
          if (st_ff.cnt == phase2_cyc - 5'h01) begin
            nxt_st.state = ATRC_CONVERT;
            nxt_st.cnt   = 5'h00;
          end
        end
        ATRC_CONVERT: begin
          if (st_ff.cnt == bits_cyc - 5'h01) begin
            nxt_st.cnt      = 5'h00;
            nxt_st.position = st_ff.position + 3'h1;
            nxt_st.convs    = st_ff.convs + 3'h1;
            if (st_ff.convs == seq_last) begin
              nxt_st.done  = 1'b1;
              nxt_st.convs = 3'h0;
              nxt_st.state = ATRC_IDLE;
              if (!fifo_mode) begin
                nxt_st.position = 3'h0;
              end
            end else begin
              nxt_st.state = ATRC_SAMPLE1;
            end
          end
        end
        default: nxt_st.state = ATRC_IDLE;
      endcase
    end
    if (abort) begin
      nxt_st.state    = ATRC_IDLE;
      nxt_st.cnt      = 5'h00;
      nxt_st.convs    = 3'h0;
      nxt_st.position = 3'h0;
      nxt_st.done     = 1'b0;
    end
    if (req.wr && req.addr == ATRC_ADDR_CONTROL3) begin
      nxt_st.ctl3 = req.wdata;
    end
    if (timing_wr) begin
      nxt_st.timing = req.wdata;
    end
    // Only a start write launches a sequence; a timing write never does.
    if (req.wr && req.addr == ATRC_ADDR_START) begin
      nxt_st.state = ATRC_SAMPLE1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff        <= '0;
      st_ff.timing <= ATRC_TIMING_RESET;
      st_ff.ctl3   <= ATRC_CTL3_RESET;
      st_ff.state  <= ATRC_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign status = '{running:  st_ff.state != ATRC_IDLE,
                    phase:    st_ff.state,
                    position: st_ff.position,
                    done:     st_ff.done};

  assign rdata_o                 = st_ff.rdata;
  assign low_resolution_select_o = st_ff.timing[ATRC_RES_BIT];
  assign sample_o                = (st_ff.state == ATRC_SAMPLE1) || (st_ff.state == ATRC_SAMPLE2);
  assign convert_o               = st_ff.state == ATRC_CONVERT;
  assign position_o              = st_ff.position;
  assign seq_done_o              = st_ff.done;

endmodule // atrc_timing_control

/* tb/atrc_timing_control_props.sv */
// Concurrent checks on the ports of the converter timing control.
`timescale 1ns/1ps
module atrc_timing_control_props
  import atrc_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       conv_clk_o,
  input wire logic       low_resolution_select_o,
  input wire logic       sample_o,
  input wire logic       convert_o,
  input wire logic [2:0] position_o,
  input wire logic       seq_done_o
);
  logic [4:0] prs_ff;
  logic [1:0] smp_ff;
  logic [5:0] run_ff;
  logic [4:0] ns_ff, nc_ff;
  logic       res_ff, cp_ff, sp_ff, vp_ff, tp_ff, ok_ff, rise, twr;
  assign rise = conv_clk_o && !cp_ff;
  assign twr  = wr_i && addr_i == ATRC_ADDR_TIMING;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // A period is only trusted once two toggles were seen since the last restart.
  always_ff @(posedge clk_i) begin
    cp_ff <= conv_clk_o;
    sp_ff <= sample_o;
    vp_ff <= convert_o;
    tp_ff <= twr;
    run_ff <= (conv_clk_o != cp_ff) ? 6'h01 : run_ff + 6'h01;
    ok_ff <= !reset_i && !twr && !tp_ff && (ok_ff || conv_clk_o != cp_ff);
    // A tick in the first cycle of a phase belongs to that phase, so it is counted as well.
    ns_ff <= sample_o ? ns_ff + 5'(rise) : 5'h00;
    nc_ff <= convert_o ? nc_ff + 5'(rise) : 5'h00;
    if (reset_i) begin
      prs_ff <= 5'h05;
      {res_ff, smp_ff} <= 3'h0;
    end else if (twr) begin
      {res_ff, smp_ff, prs_ff} <= wdata_i;
    end
  end
  property p_abort; twr |=> !sample_o && !convert_o && !seq_done_o && position_o == 3'h0; endproperty
  a_abort: assert property (p_abort) else $error("abort left sequence state");
  property p_nostart; twr ##1 !wr_i |=> !sample_o && !convert_o; endproperty
  a_nostart: assert property (p_nostart) else $error("sequence began after timing write");
  property p_res; twr |=> low_resolution_select_o == $past(wdata_i[ATRC_RES_BIT]); endproperty
  a_res: assert property (p_res) else $error("resolution output wrong");
  property p_rdback; twr ##1 !wr_i ##1 (rd_i && addr_i == ATRC_ADDR_TIMING) |=> rdata_o == $past(wdata_i, 3);
  endproperty
  a_rdback: assert property (p_rdback) else $error("timing readback wrong");
  property p_rdidle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_rdidle: assert property (p_rdidle) else $error("read data outside read slot");
  property p_div; ok_ff && conv_clk_o != cp_ff |-> run_ff == {1'b0, prs_ff} + 6'h01; endproperty
  a_div: assert property (p_div) else $error("conversion clock half period wrong");
  property p_samp; sp_ff && !sample_o && !$past(wr_i) |-> ns_ff + 5'(rise) == 5'h02 + (5'h02 << smp_ff); endproperty
  a_samp: assert property (p_samp) else $error("sample length wrong");
  property p_conv; vp_ff && !convert_o && !$past(wr_i) |-> nc_ff + 5'(rise) == (res_ff ? 5'h08 : 5'h0A); endproperty
  a_conv: assert property (p_conv) else $error("conversion length wrong");
  property p_order; $fell(sample_o) && !$past(wr_i) |-> convert_o; endproperty
  a_order: assert property (p_order) else $error("sampling not followed by conversion");
endmodule // atrc_timing_control_props

/* tb/atrc_timing_control_tb.sv */
// Self-checking bench of the converter timing control.
`timescale 1ns/1ps
module atrc_timing_control_tb;
  import atrc_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [2:0]  addr_i = 3'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  rdata_o, t;
  logic [2:0]  position_o;
  logic        conv_clk_o, low_resolution_select_o, sample_o, convert_o, seq_done_o;
  logic [31:0] seed = 32'h0000_7127;
  int          errors = 0;
  int          checked = 0;
  always #4 clk_i = ~clk_i;
  atrc_timing_control uut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .conv_clk_o(conv_clk_o), .low_resolution_select_o(low_resolution_select_o),
    .sample_o(sample_o), .convert_o(convert_o), .position_o(position_o), .seq_done_o(seq_done_o));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] st(input logic d, input logic [2:0] p);
    return {d, 4'h0, p};
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
    checked++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e, "read data");
  endtask
  // The bound covers the slowest divider with the longest sample phase.
  task automatic wait_done();
    int k;
    for (k = 0; k < 20000; k++) begin
      @(posedge clk_i);
      #1;
      if (seq_done_o === 1'b1) break;
    end
    if (k == 20000) begin
      errors++;
      give_verdict();
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(ATRC_ADDR_TIMING, ATRC_TIMING_RESET);
    rd(ATRC_ADDR_CONTROL3, ATRC_CTL3_RESET);
    rd(3'h7, 8'h00);
    for (int i = 0; i < 6; i++) begin
      t = xs();
      t[6:5] = 2'(i);
      // Only the largest divider keeps the conversion clock at or below 2 MHz on a 125 MHz bus clock.
      t[4:0] = 5'h1F;
      wr(ATRC_ADDR_TIMING, t);
      wr(ATRC_ADDR_START, 8'h00);
      wait_done();
      chk({7'h00, low_resolution_select_o}, {7'h00, t[7]}, "resolution");
      rd(ATRC_ADDR_STATUS, st(1'b1, 3'h0));
      rd(ATRC_ADDR_TIMING, t);
      wr(ATRC_ADDR_START, 8'h00);
      repeat (xs() % 40) @(posedge clk_i);
      wr(ATRC_ADDR_TIMING, t);
      rd(ATRC_ADDR_TIMING, t);
      rd(ATRC_ADDR_STATUS, st(1'b0, 3'h0));
      $display("test %0d done", i);
    end
    wr(ATRC_ADDR_CONTROL3, 8'h0C);
    wr(ATRC_ADDR_START, 8'h00);
    wait_done();
    rd(ATRC_ADDR_STATUS, st(1'b1, 3'h1));
    wr(ATRC_ADDR_TIMING, t);
    rd(ATRC_ADDR_STATUS, st(1'b0, 3'h0));
    $display("test fifo abort done");
    give_verdict();
  end
endmodule // atrc_timing_control_tb
bind atrc_timing_control atrc_timing_control_props u_props (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_clk_o(conv_clk_o),
  .low_resolution_select_o(low_resolution_select_o), .sample_o(sample_o), .convert_o(convert_o),
  .position_o(position_o), .seq_done_o(seq_done_o));
